//--- rtl/mgmt_ident_adv_regs.sv
// Serial management slave serving identifier and advertisement registers
module mgmt_ident_adv_regs #(
  parameter logic [23:0] VENDOR_OUI = 24'h5a3c96, // Arbitrary value
  parameter logic [5:0] MODEL_NUMBER = 6'h15, // Arbitrary value
  parameter logic [3:0] MODEL_REVISION = 4'h3, // Arbitrary value
  parameter logic [4:0] PHY_ADDRESS = 5'h01,
  parameter int PREAMBLE_LEN = phy_regs_pkg::PREAMBLE_BITS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic an_ack,
  output logic [15:0] adv_word
);

  typedef enum logic [7:0] {
    ST_PREAMBLE = 8'h01,
    ST_START = 8'h02,
    ST_OPCODE = 8'h04,
    ST_PHYAD = 8'h08,
    ST_REGAD = 8'h10,
    ST_TA = 8'h20,
    ST_READ = 8'h40,
    ST_WRITE = 8'h80
  } frame_state_t;

  localparam logic [5:0] PRE_LEN = 6'(PREAMBLE_LEN);
  localparam logic [5:0] PRE_MAX = 6'(phy_regs_pkg::PREAMBLE_BITS);
  localparam logic [4:0] OP_LAST = 5'(phy_regs_pkg::OP_BITS - 1);
  localparam logic [4:0] ADDR_LAST = 5'(phy_regs_pkg::ADDR_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(phy_regs_pkg::DATA_BITS - 1);

  generate
    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > phy_regs_pkg::PREAMBLE_BITS) begin : g_bad_pre
      $error("PREAMBLE_LEN must lie between 1 and 32");
    end
  endgenerate

  // Pin synchronisers and clock edge detection
  logic mdc_s;
  logic mdio_s;
  logic mdc_d_reg;
  logic mdc_d_next;
  logic mdc_rise;

  pin_sync #(
    .WIDTH(1)
  ) u_sync_mdc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(mdc),
    .sync_out(mdc_s)
  );

  pin_sync #(
    .WIDTH(1)
  ) u_sync_mdio (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(mdio_in),
    .sync_out(mdio_s)
  );

  always_comb begin
    mdc_d_next = mdc_s;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_d_reg <= 1'b0;
    end else begin
      mdc_d_reg <= mdc_d_next;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d_reg;

  // Fixed identifier words; top two vendor bits unused
  logic [15:0] id_high_word;
  logic [15:0] id_low_word;

  assign id_high_word = VENDOR_OUI[phy_regs_pkg::OUI_KEEP_MSB:phy_regs_pkg::OUI_HIGH_LSB];
  assign id_low_word = {VENDOR_OUI[phy_regs_pkg::OUI_LOW_MSB:0],
                        MODEL_NUMBER,
                        MODEL_REVISION};

  // Read data selection; reading changes nothing
  function automatic logic [15:0] read_word(input logic [4:0] addr, input logic [15:0] adv);
    logic [15:0] value;
    value = phy_regs_pkg::UNMAPPED_READ;
    case (addr)
      phy_regs_pkg::REG_ID_HIGH: value = id_high_word;
      phy_regs_pkg::REG_ID_LOW: value = id_low_word;
      phy_regs_pkg::REG_ADVERT: value = adv;
      default: value = phy_regs_pkg::UNMAPPED_READ;
    endcase
    return value;
  endfunction

  // Frame sequencer state
  frame_state_t state_reg;
  frame_state_t state_next;
  logic [4:0] bit_cnt_reg;
  logic [4:0] bit_cnt_next;
  logic [5:0] ones_cnt_reg;
  logic [5:0] ones_cnt_next;
  logic [1:0] op_reg;
  logic [1:0] op_next;
  logic [4:0] phyad_reg;
  logic [4:0] phyad_next;
  logic [4:0] regad_reg;
  logic [4:0] regad_next;
  logic ta_first_reg;
  logic ta_first_next;
  logic ta_ok_reg;
  logic ta_ok_next;

  // Data path and pin driver state
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;

  // Write port toward the advertisement store
  logic wr_en_reg;
  logic wr_en_next;
  logic [15:0] wr_data_reg;
  logic [15:0] wr_data_next;

  logic addr_hit;
  logic is_read;
  logic is_write;

  assign addr_hit = (phyad_reg == PHY_ADDRESS);
  assign is_read = (op_reg == phy_regs_pkg::OP_READ);
  assign is_write = (op_reg == phy_regs_pkg::OP_WRITE);

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    ones_cnt_next = ones_cnt_reg;
    op_next = op_reg;
    phyad_next = phyad_reg;
    regad_next = regad_reg;
    ta_first_next = ta_first_reg;
    ta_ok_next = ta_ok_reg;
    shift_next = shift_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    wr_en_next = 1'b0;
    wr_data_next = wr_data_reg;
    if (mdc_rise) begin
      case (state_reg)
        ST_PREAMBLE: begin
          if (mdio_s) begin
            if (ones_cnt_reg != PRE_MAX) begin
              ones_cnt_next = ones_cnt_reg + 6'h01;
            end
          end else if (ones_cnt_reg >= PRE_LEN) begin
            // First start bit seen after enough preamble
            state_next = ST_START;
          end else begin
            ones_cnt_next = 6'h00;
          end
        end
        ST_START: begin
          ones_cnt_next = 6'h00;
          bit_cnt_next = 5'h00;
          if (mdio_s) begin
            state_next = ST_OPCODE;
          end else begin
            state_next = ST_PREAMBLE;
          end
        end
        ST_OPCODE: begin
          op_next = {op_reg[0], mdio_s};
          if (bit_cnt_reg == OP_LAST) begin
            bit_cnt_next = 5'h00;
            state_next = ST_PHYAD;
          end else begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        ST_PHYAD: begin
          phyad_next = {phyad_reg[3:0], mdio_s};
          if (bit_cnt_reg == ADDR_LAST) begin
            bit_cnt_next = 5'h00;
            state_next = ST_REGAD;
          end else begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        ST_REGAD: begin
          regad_next = {regad_reg[3:0], mdio_s};
          if (bit_cnt_reg == ADDR_LAST) begin
            bit_cnt_next = 5'h00;
            // Snapshot read data before the turnaround
            shift_next = read_word({regad_reg[3:0], mdio_s}, adv_word);
            if (is_read || is_write) begin
              state_next = ST_TA;
            end else begin
              state_next = ST_PREAMBLE;
            end
          end else begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        ST_TA: begin
          if (bit_cnt_reg == 5'h00) begin
            bit_cnt_next = 5'h01;
            ta_first_next = mdio_s;
            if (is_read && addr_hit) begin
              // Second turnaround bit is driven low
              oe_next = 1'b1;
              out_next = 1'b0;
            end
          end else begin
            bit_cnt_next = 5'h00;
            if (is_read) begin
              state_next = ST_READ;
              if (addr_hit) begin
                out_next = shift_reg[15];
                shift_next = {shift_reg[14:0], 1'b0};
              end
            end else begin
              ta_ok_next = ({ta_first_reg, mdio_s} == phy_regs_pkg::TA_WRITE);
              state_next = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (bit_cnt_reg == DATA_LAST) begin
            // Release the line after the last data bit
            oe_next = 1'b0;
            out_next = 1'b0;
            bit_cnt_next = 5'h00;
            state_next = ST_PREAMBLE;
          end else begin
            if (addr_hit) begin
              out_next = shift_reg[15];
            end
            shift_next = {shift_reg[14:0], 1'b0};
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        ST_WRITE: begin
          shift_next = {shift_reg[14:0], mdio_s};
          if (bit_cnt_reg == DATA_LAST) begin
            bit_cnt_next = 5'h00;
            state_next = ST_PREAMBLE;
            // Only the advertisement word takes writes
            if (addr_hit && ta_ok_reg && regad_reg == phy_regs_pkg::REG_ADVERT) begin
              wr_en_next = 1'b1;
              wr_data_next = {shift_reg[14:0], mdio_s};
            end
          end else begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
          end
        end
        default: begin
          state_next = ST_PREAMBLE;
          bit_cnt_next = 5'h00;
          ones_cnt_next = 6'h00;
          oe_next = 1'b0;
          out_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_PREAMBLE;
      bit_cnt_reg <= 5'h00;
      ones_cnt_reg <= 6'h00;
      op_reg <= 2'h0;
      phyad_reg <= 5'h00;
      regad_reg <= 5'h00;
      ta_first_reg <= 1'b0;
      ta_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      ones_cnt_reg <= ones_cnt_next;
      op_reg <= op_next;
      phyad_reg <= phyad_next;
      regad_reg <= regad_next;
      ta_first_reg <= ta_first_next;
      ta_ok_reg <= ta_ok_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= 16'h0000;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_en_reg <= 1'b0;
      wr_data_reg <= 16'h0000;
    end else begin
      wr_en_reg <= wr_en_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // Advertisement register; reserved bits stored as written
  adv_store u_adv_store (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(wr_en_reg),
    .wr_data(wr_data_reg),
    .an_ack(an_ack),
    .adv_value(adv_word)
  );

  assign mdio_out = out_reg;
  assign mdio_oe = oe_reg;

endmodule

//--- shared/phy_regs_pkg.sv
// Constants for the identifier and advertisement management registers
package phy_regs_pkg;

  // Register addresses on the management bus
  localparam logic [4:0] REG_ID_HIGH = 5'h02;
  localparam logic [4:0] REG_ID_LOW = 5'h03;
  localparam logic [4:0] REG_ADVERT = 5'h04;

  // Identifier field layout
  localparam int OUI_KEEP_MSB = 21;
  localparam int OUI_HIGH_LSB = 6;
  localparam int OUI_LOW_MSB = 5;
  localparam int ID_LOW_OUI_POS = 10;
  localparam int ID_LOW_MODEL_POS = 4;
  localparam int ID_LOW_REV_POS = 0;

  // Advertisement field positions
  localparam int ADV_NEXT_PAGE_POS = 15;
  localparam int ADV_ACK_POS = 14;
  localparam int ADV_REMOTE_FAULT_POS = 13;
  localparam int ADV_RSVD_HI_POS = 12;
  localparam int ADV_RSVD_LO_POS = 11;
  localparam int ADV_PAUSE_POS = 10;
  localparam int ADV_FOURPAIR_POS = 9;
  localparam int ADV_FAST_FDX_POS = 8;
  localparam int ADV_FAST_HDX_POS = 7;
  localparam int ADV_TEN_FDX_POS = 6;
  localparam int ADV_TEN_HDX_POS = 5;
  localparam int ADV_SELECTOR_MSB = 4;
  localparam int ADV_SELECTOR_LSB = 0;

  // Advertisement reset value and writable bits
  localparam logic [4:0] SELECTOR_CSMA_CD = 5'h01;
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [15:0] ADV_WRITE_MASK = 16'h3dff;

  // Management frame layout
  localparam int PREAMBLE_BITS = 32;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] TA_WRITE = 2'b10;
  localparam int OP_BITS = 2;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 16;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1");
    end
  endgenerate

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

//--- rtl/adv_store.sv
// Advertisement register storage with fixed and hardware-driven bits
module adv_store (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic an_ack,
  output logic [15:0] adv_value
);

  logic [15:0] adv_reg;
  logic [15:0] adv_next;

  always_comb begin
    adv_next = adv_reg;
    if (wr_en) begin
      adv_next = (adv_reg & ~phy_regs_pkg::ADV_WRITE_MASK) |
                 (wr_data & phy_regs_pkg::ADV_WRITE_MASK);
    end
    // No next page and no four-pair mode offered
    adv_next[phy_regs_pkg::ADV_NEXT_PAGE_POS] = 1'b0;
    adv_next[phy_regs_pkg::ADV_FOURPAIR_POS] = 1'b0;
    // Acknowledge follows negotiation logic, never software
    adv_next[phy_regs_pkg::ADV_ACK_POS] = an_ack;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      adv_reg <= phy_regs_pkg::ADV_RESET;
    end else begin
      adv_reg <= adv_next;
    end
  end

  assign adv_value = adv_reg;

endmodule

//--- tb/mgmt_ident_adv_regs_properties.sv
// Concurrent checks on the management register block ports
module mgmt_regs_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic an_ack,
  input wire logic [15:0] adv_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_adv_reset_value: assert property ($past(sys_rst) |-> (adv_word & 16'hbfff) == 16'h01e1)
    else $error("advertisement word not at reset value");
  chk_next_page_zero: assert property (!adv_word[15])
    else $error("next page bit set");
  chk_fourpair_zero: assert property (!adv_word[9])
    else $error("four-pair ability bit set");
  chk_ack_follows: assert property (!$past(sys_rst) |-> adv_word[14] == $past(an_ack))
    else $error("acknowledge bit does not follow negotiation logic");
  // Writable bits only move shortly after a management clock rise
  chk_adv_quiet: assert property ((!mdc) [*8] |=> $stable(adv_word & 16'hbfff))
    else $error("advertisement word changed without a frame");
  chk_oe_after_mdc: assert property ($rose(mdio_oe) |->
    ($past(mdc, 2) || $past(mdc, 3) || $past(mdc, 4) || $past(mdc, 5)))
    else $error("pin driven without a management clock rise");
  chk_turnaround_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not driven low");
  chk_idle_released: assert property ((!mdc) [*8] |-> !mdio_oe)
    else $error("pin still driven while bus idle");

  cover property ($rose(mdio_oe));
  cover property ($changed(adv_word[8:5]));
  cover property ($rose(adv_word[14]));
endmodule

//--- tb/mgmt_station.sv
// Station management controller model issuing frames on mdc and the data pin
module mgmt_station (
  input wire logic mclk,
  input wire logic pin,
  output logic mdc,
  output logic drv_en,
  output logic drv_val
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end

  // Five cycles low with data set up, then five cycles high
  task automatic bit_cycle(input logic en, input logic val, output logic seen);
    @(posedge mclk);
    mdc <= 1'b0;
    drv_en <= en;
    drv_val <= val;
    repeat (5) @(posedge mclk);
    seen = pin;
    mdc <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                       input logic [1:0] ta, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [13:0] hdr;
    logic seen;
    logic rd;
    rd = (op == phy_regs_pkg::OP_READ);
    hdr = {2'b01, op, phy, regad};
    for (int i = 0; i < phy_regs_pkg::PREAMBLE_BITS; i++) bit_cycle(1'b1, 1'b1, seen);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], seen);
    for (int i = 1; i >= 0; i--) bit_cycle(!rd, ta[i], seen);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(!rd, wdata[i] && i != 14 && i != 12 && i != 11, seen);
      rdata[i] = seen;
    end
    // Clock stands still and the pin is released between frames
    @(posedge mclk);
    mdc <= 1'b0;
    drv_en <= 1'b0;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the identifier and advertisement registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] OUI = 24'h3c5a69; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h2b; // Arbitrary value
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  localparam logic [4:0] PHY = 5'h07;
  localparam logic [4:0] ADV = phy_regs_pkg::REG_ADVERT;
  logic mclk = 1'b0;
  logic sys_rst;
  logic an_ack;
  logic mdc;
  logic drv_en;
  logic drv_val;
  logic mdio_out;
  logic mdio_oe;
  logic [15:0] adv_word;
  logic [15:0] rd;
  wire logic pin;
  int n_errors = 0;
  int checks = 0;

  // Pull-up when nobody drives
  assign pin = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

  always #5 mclk = ~mclk;

  mgmt_ident_adv_regs #(.VENDOR_OUI(OUI), .MODEL_NUMBER(MODEL), .MODEL_REVISION(REV),
    .PHY_ADDRESS(PHY), .PREAMBLE_LEN(32)) mgmt_ident_adv_regs_i (.mclk(mclk),
    .sys_rst(sys_rst), .mdc(mdc), .mdio_in(pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .an_ack(an_ack), .adv_word(adv_word));

  mgmt_station mgmt_station_i (.mclk(mclk), .pin(pin), .mdc(mdc), .drv_en(drv_en),
    .drv_val(drv_val));

  task automatic expect16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [4:0] regad, input logic [15:0] d);
    mgmt_station_i.frame(phy_regs_pkg::OP_WRITE, PHY, regad, phy_regs_pkg::TA_WRITE, d, rd);
    repeat (4) @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [4:0] regad, input logic [15:0] exp);
    mgmt_station_i.frame(phy_regs_pkg::OP_READ, PHY, regad, 2'b00, 16'h0000, rd);
    expect16($sformatf("register %h", regad), exp, rd);
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    an_ack = 1'b0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    expect16("adv_word", 16'h01e1, adv_word);
    rd_chk(phy_regs_pkg::REG_ID_HIGH, OUI[21:6]);
    rd_chk(phy_regs_pkg::REG_ID_LOW, {OUI[5:0], MODEL, REV});
    wr(phy_regs_pkg::REG_ID_HIGH, ~OUI[21:6]);
    wr(phy_regs_pkg::REG_ID_LOW, 16'hffff);
    rd_chk(phy_regs_pkg::REG_ID_HIGH, OUI[21:6]);
    rd_chk(phy_regs_pkg::REG_ID_LOW, {OUI[5:0], MODEL, REV});
    rd_chk(ADV, 16'h01e1);
    rd_chk(ADV, 16'h01e1);
    wr(ADV, 16'hffff);
    expect16("adv_word", 16'h25ff, adv_word);
    rd_chk(ADV, 16'h25ff);
    wr(ADV, 16'h0000);
    rd_chk(ADV, 16'h0000);
    an_ack <= 1'b1;
    repeat (2) @(posedge mclk);
    expect16("adv_word", 16'h4000, adv_word);
    rd_chk(ADV, 16'h4000);
    an_ack <= 1'b0;
    wr(5'h05, 16'h0021);
    mgmt_station_i.frame(phy_regs_pkg::OP_WRITE, PHY ^ 5'h01, ADV, 2'b10, 16'h0021, rd);
    mgmt_station_i.frame(phy_regs_pkg::OP_READ, PHY ^ 5'h01, ADV, 2'b00, 16'h0000, rd);
    expect16("foreign read", 16'hffff, rd);
    mgmt_station_i.frame(phy_regs_pkg::OP_WRITE, PHY, ADV, 2'b11, 16'h0021, rd);
    // Undefined opcode: frame abandoned, nothing written
    mgmt_station_i.frame(2'b11, PHY, ADV, 2'b10, 16'h0021, rd);
    rd_chk(ADV, 16'h0000);
    rd_chk(5'h05, phy_regs_pkg::UNMAPPED_READ);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    rd_chk(ADV, 16'h01e1);
    give_verdict();
  end
endmodule

bind mgmt_ident_adv_regs mgmt_regs_checker mgmt_regs_checker_i (.mclk(mclk),
  .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .an_ack(an_ack),
  .adv_word(adv_word));
